/* File: hdl/run_gate_pkg.sv */
/*
 * Constants for the run-mode unit clock gating block: bus addresses,
 * gate bit layout, reset values and the compact unit index order.
 * Assumes a 32-bit register port with full byte addresses.
 */
package run_gate_pkg;

    // System control block base and register offsets
    localparam logic [31:0] SYSCTL_BASE     = 32'h400F_E000;
    localparam logic [31:0] RUN_GATE_OFS    = 32'h0000_0104;
    localparam logic [31:0] SLEEP_GATE_OFS  = 32'h0000_0114;
    localparam logic [31:0] DEEP_GATE_OFS   = 32'h0000_0124;
    localparam logic [31:0] RUN_CFG_OFS     = 32'h0000_0130;

    localparam logic [31:0] RUN_GATE_ADDR   = SYSCTL_BASE + RUN_GATE_OFS;
    localparam logic [31:0] SLEEP_GATE_ADDR = SYSCTL_BASE + SLEEP_GATE_OFS;
    localparam logic [31:0] DEEP_GATE_ADDR  = SYSCTL_BASE + DEEP_GATE_OFS;
    localparam logic [31:0] RUN_CFG_ADDR    = SYSCTL_BASE + RUN_CFG_OFS;

    // Number of gated units
    localparam int UNIT_COUNT = 10;

    // Gate bit positions in compact unit order:
    // 0 async_serial0, 1 async_serial1, 2 sync_serial0,
    // 3..6 gp_counter0..3, 7..9 comparator0..2
    localparam int GATE_POS [0:UNIT_COUNT-1] =
        '{0, 1, 4, 16, 17, 18, 19, 24, 25, 26};

    // Writable gate bits; everything else is reserved and reads zero
    localparam logic [31:0] GATE_WRITE_MASK = 32'h070F_0013;
    localparam logic [31:0] GATE_RESET      = 32'h0000_0000;

    // Run configuration: only the automatic sleep gating select
    localparam int          AUTO_GATE_POS   = 0;
    localparam logic        AUTO_GATE_RESET = 1'b0;

    localparam logic [31:0] RDATA_IDLE      = 32'h0000_0000;

endpackage

/* File: hdl/run_mode_clock_gating.sv */
/*
 * Run-mode unit clock gating register with its sleep and deep-sleep
 * counterparts and the automatic sleep gating select. Drives one clock
 * enable per unit and flags bus accesses aimed at unclocked units.
 * Assumes: glitch-free clock gate cells sit outside this block, the
 * bus fabric raises i_unit_access for one cycle per unit access, and
 * the power controller drives i_sleep and i_deep_sleep on i_clk.
 */

`timescale 1ns/1ns
`default_nettype none

module run_mode_clock_gating (
    input  wire logic        i_clk,
    input  wire logic        i_reset,
    input  wire logic [31:0] i_addr,
    input  wire logic [31:0] i_wdata,
    input  wire logic        i_write,
    input  wire logic        i_read,
    output logic      [31:0] o_rdata,
    input  wire logic        i_sleep,
    input  wire logic        i_deep_sleep,
    input  wire logic  [9:0] i_unit_access,
    output logic       [9:0] o_unit_clk_en,
    output logic       [9:0] o_unit_fault
);

    localparam int N = run_gate_pkg::UNIT_COUNT;

    logic [31:0]  run_gate_r;
    logic [31:0]  sleep_gate_r;
    logic [31:0]  deep_gate_r;
    logic         auto_gate_r;
    logic [N-1:0] clk_en_r;
    logic [N-1:0] clk_en_nxt;
    logic [N-1:0] fault_r;
    logic [31:0]  rdata_r;
    logic [31:0]  rdata_nxt;
    logic         wr_run;
    logic         wr_sleep;
    logic         wr_deep;
    logic         wr_cfg;

    // Gather the scattered gate bits into compact unit order
    function automatic logic [N-1:0] gate_pack(input logic [31:0] word);
        logic [N-1:0] v;
        v = '0;
        for (int i = 0; i < N; i++) begin
            v[i] = word[run_gate_pkg::GATE_POS[i]];
        end
        return v;
    endfunction

    // Full 32-bit compare so aliases never hit a gate register
    assign wr_run   = i_write && (i_addr == run_gate_pkg::RUN_GATE_ADDR);
    assign wr_sleep = i_write && (i_addr == run_gate_pkg::SLEEP_GATE_ADDR);
    assign wr_deep  = i_write && (i_addr == run_gate_pkg::DEEP_GATE_ADDR);
    assign wr_cfg   = i_write && (i_addr == run_gate_pkg::RUN_CFG_ADDR);

    // Run gate register; reserved bits never store anything
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            run_gate_r <= run_gate_pkg::GATE_RESET;
        end else if (wr_run) begin
            run_gate_r <= i_wdata & run_gate_pkg::GATE_WRITE_MASK;
        end
    end

    // Sleep counterpart, same layout
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            sleep_gate_r <= run_gate_pkg::GATE_RESET;
        end else if (wr_sleep) begin
            sleep_gate_r <= i_wdata & run_gate_pkg::GATE_WRITE_MASK;
        end
    end

    // Deep-sleep counterpart, same layout
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            deep_gate_r <= run_gate_pkg::GATE_RESET;
        end else if (wr_deep) begin
            deep_gate_r <= i_wdata & run_gate_pkg::GATE_WRITE_MASK;
        end
    end

    // Automatic sleep gating select
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            auto_gate_r <= run_gate_pkg::AUTO_GATE_RESET;
        end else if (wr_cfg) begin
            auto_gate_r <= i_wdata[run_gate_pkg::AUTO_GATE_POS];
        end
    end

    // Deep sleep outranks sleep; without auto gating run settings hold
    always_comb begin
        if (auto_gate_r && i_deep_sleep) begin
            clk_en_nxt = gate_pack(deep_gate_r);
        end else if (auto_gate_r && i_sleep) begin
            clk_en_nxt = gate_pack(sleep_gate_r);
        end else begin
            clk_en_nxt = gate_pack(run_gate_r);
        end
    end

    // Registered enables give the one-cycle lag after a write and keep
    // the gate cell inputs free of decode glitches
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            clk_en_r <= '0;
        end else begin
            clk_en_r <= clk_en_nxt;
        end
    end

    // Fault judged against the enable the unit actually sees
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            fault_r <= '0;
        end else begin
            fault_r <= i_unit_access & ~clk_en_r;
        end
    end

    // Read mux; unmapped addresses read zero
    always_comb begin
        if (i_addr == run_gate_pkg::RUN_GATE_ADDR) begin
            rdata_nxt = run_gate_r;
        end else if (i_addr == run_gate_pkg::SLEEP_GATE_ADDR) begin
            rdata_nxt = sleep_gate_r;
        end else if (i_addr == run_gate_pkg::DEEP_GATE_ADDR) begin
            rdata_nxt = deep_gate_r;
        end else if (i_addr == run_gate_pkg::RUN_CFG_ADDR) begin
            rdata_nxt = run_gate_pkg::RDATA_IDLE;
            rdata_nxt[run_gate_pkg::AUTO_GATE_POS] = auto_gate_r;
        end else begin
            rdata_nxt = run_gate_pkg::RDATA_IDLE;
        end
    end

    // Read data stand for exactly one cycle after the strobe
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            rdata_r <= run_gate_pkg::RDATA_IDLE;
        end else if (i_read) begin
            rdata_r <= rdata_nxt;
        end else begin
            rdata_r <= run_gate_pkg::RDATA_IDLE;
        end
    end

    assign o_rdata       = rdata_r;
    assign o_unit_clk_en = clk_en_r;
    assign o_unit_fault  = fault_r;

    // A run write outside low power reaches the enables two edges later
    AST_RUN_WRITE_TO_EN:
    assert property (@(posedge i_clk) disable iff (i_reset)
        (wr_run && !i_sleep && !i_deep_sleep)
        ##1 (!wr_run && !i_sleep && !i_deep_sleep)
        |=> (o_unit_clk_en ==
             gate_pack($past(i_wdata, 2) & run_gate_pkg::GATE_WRITE_MASK)))
    else $error("run gate write did not reach the clock enables");

    // New enables must not appear in the cycle right after the write;
    // compared against the old register so back-to-back writes are legal
    AST_EN_NOT_EARLY:
    assert property (@(posedge i_clk) disable iff (i_reset)
        (wr_run && !i_sleep && !i_deep_sleep)
        |=> (o_unit_clk_en == gate_pack($past(run_gate_r))))
    else $error("clock enables changed too early after a run write");

    AST_FAULT_WHEN_GATED:
    assert property (@(posedge i_clk) disable iff (i_reset)
        1'b1 |=> (o_unit_fault == $past(i_unit_access & ~o_unit_clk_en)))
    else $error("bus fault does not match access to unclocked unit");

    AST_NO_FAULT_WHEN_CLOCKED:
    assert property (@(posedge i_clk) disable iff (i_reset)
        ((i_unit_access & o_unit_clk_en) != '0)
        |=> ((o_unit_fault & $past(i_unit_access)
              & $past(o_unit_clk_en)) == '0))
    else $error("clocked unit answered with a bus fault");

    AST_RESET_CLEARS:
    assert property (@(posedge i_clk)
        i_reset |=> (run_gate_r == '0 && sleep_gate_r == '0
                     && deep_gate_r == '0 && o_unit_clk_en == '0))
    else $error("gate state not cleared by reset");

    AST_RESERVED_ZERO:
    assert property (@(posedge i_clk) disable iff (i_reset)
        ((run_gate_r | sleep_gate_r | deep_gate_r)
         & ~run_gate_pkg::GATE_WRITE_MASK) == '0)
    else $error("reserved gate bit holds a one");

    AST_RUN_READBACK:
    assert property (@(posedge i_clk) disable iff (i_reset)
        (i_read && i_addr == run_gate_pkg::RUN_GATE_ADDR)
        |=> (o_rdata == $past(run_gate_r)
             && (o_rdata & ~run_gate_pkg::GATE_WRITE_MASK) == '0))
    else $error("run gate register read back wrong");

    AST_OTHER_ADDR_NO_RUN_WRITE:
    assert property (@(posedge i_clk) disable iff (i_reset)
        (i_write && i_addr != run_gate_pkg::RUN_GATE_ADDR)
        |=> $stable(run_gate_r))
    else $error("run gate register changed on a foreign address");

    AST_READ_DATA_ONE_CYCLE:
    assert property (@(posedge i_clk) disable iff (i_reset)
        !i_read |=> (o_rdata == run_gate_pkg::RDATA_IDLE))
    else $error("read data stood outside the answer cycle");

    AST_SLEEP_AUTO:
    assert property (@(posedge i_clk) disable iff (i_reset)
        (auto_gate_r && i_sleep && !i_deep_sleep)
        |=> (o_unit_clk_en == gate_pack($past(sleep_gate_r))))
    else $error("sleep gating not applied under auto gating");

    AST_DEEP_AUTO:
    assert property (@(posedge i_clk) disable iff (i_reset)
        (auto_gate_r && i_deep_sleep)
        |=> (o_unit_clk_en == gate_pack($past(deep_gate_r))))
    else $error("deep-sleep gating not applied under auto gating");

    AST_SLEEP_KEEPS_RUN:
    assert property (@(posedge i_clk) disable iff (i_reset)
        (!auto_gate_r && (i_sleep || i_deep_sleep))
        |=> (o_unit_clk_en == gate_pack($past(run_gate_r))))
    else $error("sleep changed gating without auto gating");

    // Outside low power the enables always follow the run register
    AST_RUN_MODE_EN:
    assert property (@(posedge i_clk) disable iff (i_reset)
        (!i_sleep && !i_deep_sleep)
        |=> (o_unit_clk_en == gate_pack($past(run_gate_r))))
    else $error("running enables differ from the run register");

    // Stored values: masked write data and nothing else
    AST_RUN_WRITE_MASKED:
    assert property (@(posedge i_clk) disable iff (i_reset)
        wr_run
        |=> (run_gate_r == ($past(i_wdata) & run_gate_pkg::GATE_WRITE_MASK)))
    else $error("run gate register stored wrong value");

    AST_SLEEP_WRITE_MASKED:
    assert property (@(posedge i_clk) disable iff (i_reset)
        wr_sleep
        |=> (sleep_gate_r == ($past(i_wdata) & run_gate_pkg::GATE_WRITE_MASK)))
    else $error("sleep gate register stored wrong value");

    AST_DEEP_WRITE_MASKED:
    assert property (@(posedge i_clk) disable iff (i_reset)
        wr_deep
        |=> (deep_gate_r == ($past(i_wdata) & run_gate_pkg::GATE_WRITE_MASK)))
    else $error("deep-sleep gate register stored wrong value");

    AST_CFG_WRITE:
    assert property (@(posedge i_clk) disable iff (i_reset)
        wr_cfg
        |=> (auto_gate_r == $past(i_wdata[run_gate_pkg::AUTO_GATE_POS])))
    else $error("auto gating select stored wrong value");

    // Registers hold between writes
    AST_RUN_HOLDS:
    assert property (@(posedge i_clk) disable iff (i_reset)
        !wr_run
        |=> $stable(run_gate_r))
    else $error("run gate register changed without a write");

    AST_SLEEP_HOLDS:
    assert property (@(posedge i_clk) disable iff (i_reset)
        !wr_sleep
        |=> $stable(sleep_gate_r))
    else $error("sleep gate register changed without a write");

    AST_DEEP_HOLDS:
    assert property (@(posedge i_clk) disable iff (i_reset)
        !wr_deep
        |=> $stable(deep_gate_r))
    else $error("deep-sleep gate register changed without a write");

    AST_CFG_HOLDS:
    assert property (@(posedge i_clk) disable iff (i_reset)
        !wr_cfg
        |=> $stable(auto_gate_r))
    else $error("auto gating select changed without a write");

    // Faults are one-cycle answers to an access, never spontaneous
    AST_FAULT_NEEDS_ACCESS:
    assert property (@(posedge i_clk) disable iff (i_reset)
        (i_unit_access == '0)
        |=> (o_unit_fault == '0))
    else $error("bus fault raised without an access");

    AST_RESET_OUTPUTS:
    assert property (@(posedge i_clk)
        i_reset
        |=> (o_unit_fault == '0 && o_rdata == run_gate_pkg::RDATA_IDLE
             && !auto_gate_r))
    else $error("outputs or auto select not cleared by reset");

    AST_SLEEP_READBACK:
    assert property (@(posedge i_clk) disable iff (i_reset)
        (i_read && i_addr == run_gate_pkg::SLEEP_GATE_ADDR)
        |=> (o_rdata == $past(sleep_gate_r)))
    else $error("sleep gate register read back wrong");

    AST_DEEP_READBACK:
    assert property (@(posedge i_clk) disable iff (i_reset)
        (i_read && i_addr == run_gate_pkg::DEEP_GATE_ADDR)
        |=> (o_rdata == $past(deep_gate_r)))
    else $error("deep-sleep gate register read back wrong");

    // Only the select bit of the configuration word ever reads one
    AST_CFG_READBACK:
    assert property (@(posedge i_clk) disable iff (i_reset)
        (i_read && i_addr == run_gate_pkg::RUN_CFG_ADDR)
        |=> (o_rdata[run_gate_pkg::AUTO_GATE_POS] == $past(auto_gate_r)
             && (o_rdata >> 1) == '0))
    else $error("run configuration read back wrong");

    AST_UNMAPPED_READ_ZERO:
    assert property (@(posedge i_clk) disable iff (i_reset)
        (i_read && i_addr != run_gate_pkg::RUN_GATE_ADDR
         && i_addr != run_gate_pkg::SLEEP_GATE_ADDR
         && i_addr != run_gate_pkg::DEEP_GATE_ADDR
         && i_addr != run_gate_pkg::RUN_CFG_ADDR)
        |=> (o_rdata == run_gate_pkg::RDATA_IDLE))
    else $error("unmapped address read nonzero");

    // With auto gating and both sleep inputs high, the deep-sleep settings win one edge later
    AST_DEEP_OUTRANKS:
    assert property (@(posedge i_clk) disable iff (i_reset)
        (auto_gate_r && i_sleep && i_deep_sleep)
        |=> (o_unit_clk_en == gate_pack($past(deep_gate_r))))
    else $error("deep sleep did not outrank sleep");

endmodule

`default_nettype wire

/* File: bench/tb_top.sv */
/*
 * Self-checking bench for the run-mode unit clock gating block.
 * Assumes the block answers reads one cycle later and updates unit
 * clock enables one edge after a gate register or mode change.
 */
`timescale 1ns/1ns
`default_nettype none

module tb_top;
    logic        i_clk         = 1'b0;
    logic        i_reset       = 1'b1;
    logic [31:0] i_addr        = 32'h0000_0000;
    logic [31:0] i_wdata       = 32'h0000_0000;
    logic        i_write       = 1'b0;
    logic        i_read        = 1'b0;
    logic        i_sleep       = 1'b0;
    logic        i_deep_sleep  = 1'b0;
    logic  [9:0] i_unit_access = 10'h000;
    logic [31:0] o_rdata;
    logic  [9:0] o_unit_clk_en;
    logic  [9:0] o_unit_fault;
    int          err_count     = 0;
    int          check_count   = 0;
    int          cycles        = 0;
    // Own copy of the bit layout so the bench does not trust the package
    int          pos [0:9]     = '{0, 1, 4, 16, 17, 18, 19, 24, 25, 26};
    localparam logic [31:0] RUN = 32'h400F_E104;
    localparam logic [31:0] SLP = 32'h400F_E114;
    localparam logic [31:0] DEP = 32'h400F_E124;
    localparam logic [31:0] CFG = 32'h400F_E130;
    localparam logic [31:0] BAD = 32'h400F_E10C;

    run_mode_clock_gating u_run_mode_clock_gating (
        .i_clk         (i_clk),
        .i_reset       (i_reset),
        .i_addr        (i_addr),
        .i_wdata       (i_wdata),
        .i_write       (i_write),
        .i_read        (i_read),
        .o_rdata       (o_rdata),
        .i_sleep       (i_sleep),
        .i_deep_sleep  (i_deep_sleep),
        .i_unit_access (i_unit_access),
        .o_unit_clk_en (o_unit_clk_en),
        .o_unit_fault  (o_unit_fault)
    );

    always #10 i_clk = ~i_clk;

    task automatic close_out();
        $display("checks %0d mismatches %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // Tests need about 140 cycles; reaching 3000 means a hang
    always @(posedge i_clk) begin
        cycles++;
        if (cycles == 3000) begin
            err_count++;
            close_out();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            err_count++;
            $display("unexpected at %0t: got %h expected %h",
                     $time, got, exp);
        end
    endtask

    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        @(posedge i_clk);
        i_write <= 1'b1;
        i_addr  <= a;
        i_wdata <= d;
        @(posedge i_clk);
        i_write <= 1'b0;
    endtask

    // Read data stands only in the cycle after the strobe
    task automatic rd_chk(input logic [31:0] a, input logic [31:0] exp);
        @(posedge i_clk);
        i_read <= 1'b1;
        i_addr <= a;
        @(posedge i_clk);
        i_read <= 1'b0;
        #1;
        chk(o_rdata, exp);
    endtask

    task automatic step(input int n);
        repeat (n) @(posedge i_clk);
        #1;
    endtask

    task automatic t_reset();
        rd_chk(RUN, 32'h0000_0000);
        rd_chk(SLP, 32'h0000_0000);
        rd_chk(DEP, 32'h0000_0000);
        rd_chk(CFG, 32'h0000_0000);
        chk({22'h0, o_unit_clk_en}, 32'h0000_0000);
        $display("test reset done");
    endtask

    task automatic t_map();
        wr(RUN, 32'hFFFF_FFFF);
        rd_chk(RUN, 32'h070F_0013);
        wr(BAD, 32'hFFFF_FFFF);
        rd_chk(BAD, 32'h0000_0000);
        rd_chk(RUN, 32'h070F_0013);
        chk({22'h0, o_unit_clk_en}, 32'h0000_03FF);
        wr(RUN, 32'hF8F0_FFEC);
        rd_chk(RUN, 32'h0000_0000);
        step(1);
        chk({22'h0, o_unit_clk_en}, 32'h0000_0000);
        $display("test map done");
    endtask

    task automatic t_units();
        logic [9:0] prev;
        prev = 10'h000;
        for (int k = 0; k < 10; k++) begin
            wr(RUN, 32'h0000_0001 << pos[k]);
            #1;
            chk({22'h0, o_unit_clk_en}, {22'h0, prev});
            step(1);
            prev = 10'h001 << k;
            chk({22'h0, o_unit_clk_en}, {22'h0, prev});
            rd_chk(RUN, 32'h0000_0001 << pos[k]);
        end
        $display("test units done");
    endtask

    task automatic t_fault();
        wr(RUN, 32'h0000_0001);
        step(1);
        for (int k = 0; k < 10; k++) begin
            @(posedge i_clk);
            i_unit_access <= 10'h001 << k;
            @(posedge i_clk);
            i_unit_access <= 10'h000;
            #1;
            chk({22'h0, o_unit_fault}, (k == 0) ? 0 : 32'h1 << k);
        end
        step(1);
        chk({22'h0, o_unit_fault}, 32'h0000_0000);
        $display("test fault done");
    endtask

    task automatic t_sleep();
        wr(SLP, 32'h0000_0010);
        wr(DEP, 32'h0100_0000);
        rd_chk(SLP, 32'h0000_0010);
        rd_chk(DEP, 32'h0100_0000);
        @(posedge i_clk);
        i_sleep <= 1'b1;
        step(2);
        chk({22'h0, o_unit_clk_en}, 32'h0000_0001);
        wr(CFG, 32'h0000_0001);
        step(1);
        chk({22'h0, o_unit_clk_en}, 32'h0000_0004);
        rd_chk(CFG, 32'h0000_0001);
        @(posedge i_clk);
        i_deep_sleep <= 1'b1;
        step(2);
        chk({22'h0, o_unit_clk_en}, 32'h0000_0080);
        @(posedge i_clk);
        i_sleep      <= 1'b0;
        i_deep_sleep <= 1'b0;
        step(2);
        chk({22'h0, o_unit_clk_en}, 32'h0000_0001);
        $display("test sleep done");
    endtask

    task automatic t_rerst();
        @(posedge i_clk);
        i_reset <= 1'b1;
        step(2);
        @(posedge i_clk);
        i_reset <= 1'b0;
        #1;
        chk({22'h0, o_unit_clk_en}, 32'h0000_0000);
        rd_chk(RUN, 32'h0000_0000);
        rd_chk(SLP, 32'h0000_0000);
        rd_chk(DEP, 32'h0000_0000);
        rd_chk(CFG, 32'h0000_0000);
        $display("test mid-run reset done");
    endtask

    initial begin
        repeat (8) @(posedge i_clk);
        i_reset <= 1'b0;
        t_reset();
        t_map();
        t_units();
        t_fault();
        t_sleep();
        t_rerst();
        close_out();
    end
endmodule

`default_nettype wire
